// [hdl/dmc_defines.svh]
// Purpose: Constants for the diagnostic output mux control
// Assumes: Registers reached through the device serial command decoder
// Notes: Field positions, reset values and loopback select codes
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH

`define DMC_CTRL_RESET 8'h00
`define DMC_SEL_RESET 8'h00
`define DMC_BIT_MUX_EN 7
`define DMC_BIT_SDO_FORCE 6
`define DMC_BIT_MAN_OUT 5
`define DMC_LBK_HI 4
`define DMC_LBK_LO 2
`define DMC_CFG_HI 1
`define DMC_CFG_LO 0
`define DMC_LBK_NONE 3'h0
`define DMC_LBK_ERR 3'h1
`define DMC_LBK_CS 3'h2
`define DMC_LBK_SDI 3'h3
`define DMC_LBK_SCK 3'h4
`define DMC_LBK_SDO 3'h7

`endif

// [hdl/dmc_pkg.sv]
// Purpose: Types for the diagnostic output mux control
// Assumes: Nothing
// Notes: Mux configuration codes
package dmc_pkg;
  typedef enum logic [1:0] {
    DMC_CFG_MANUAL = 2'h0,
    DMC_CFG_DIGITAL = 2'h1,
    DMC_CFG_ANALOG = 2'h2,
    DMC_CFG_LOOPBACK = 2'h3
  } dmc_cfg_t;
endpackage

// [hdl/dmc_loopback_sel.sv]
// Purpose: Pick the pin that is looped back to the diagnostic output
// Assumes: Inputs synchronous to the device clock
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defines.svh"
module dmc_loopback_sel (
  // Selection
  input wire logic [2:0] loopback_input_select,
  input wire logic serial_out_force_level,
  // Pins
  input wire logic error_in,
  input wire logic chip_select_pin,
  input wire logic sdi_in,
  input wire logic sck_in,
  // Result
  output logic active,
  output logic level
);
  // -------------------------------------------------------------
  // Loopback decode
  // -------------------------------------------------------------
  always_comb begin
    active = 1'b1;
    level = 1'b0;
    case (loopback_input_select)
      `DMC_LBK_ERR: level = error_in;
      `DMC_LBK_CS: level = chip_select_pin;
      `DMC_LBK_SDI: level = sdi_in;
      `DMC_LBK_SCK: level = sck_in;
      `DMC_LBK_SDO: level = serial_out_force_level;
      default: active = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [hdl/dmc_diag_mux_ctrl.sv]
// Purpose: Diagnostic output mux and input pin interconnect test control
// Assumes: Command decoder gives write strobes; pins synchronous to clk
// Notes: Analog path releases the pin; analog switch is on only with loopback select none
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defines.svh"
module dmc_diag_mux_ctrl
  import dmc_pkg::*;
#(
  parameter int NUM_CH = 256
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic device_reset_state,
  // Register access from command decoder
  input wire logic ctrl_wr_en,
  input wire logic [7:0] ctrl_wr_data,
  input wire logic ctrl_lock,
  input wire logic sel_wr_en,
  input wire logic [7:0] sel_wr_data,
  output logic [7:0] diag_control_reg,
  output logic [7:0] diag_channel_select,
  // Pins under test
  input wire logic error_in,
  input wire logic chip_select_pin,
  input wire logic sdi_in,
  input wire logic sck_in,
  // Serial data out from the serial interface
  input wire logic sdo_func_data,
  input wire logic sdo_func_oe,
  output logic sdo_out,
  output logic sdo_oe,
  // Internal diagnostic channels
  input wire logic [NUM_CH-1:0] digital_channels,
  // Diagnostic pin and analog switch
  output logic diag_output_pin,
  output logic diag_output_oe,
  output logic analog_mux_en,
  output logic [7:0] analog_mux_sel
);
  // -------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] sel_r;

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= `DMC_CTRL_RESET;
    end else if (device_reset_state) begin
      ctrl_r <= `DMC_CTRL_RESET;
    end else if (ctrl_wr_en && !ctrl_lock) begin
      ctrl_r <= ctrl_wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_r <= `DMC_SEL_RESET;
    end else if (device_reset_state) begin
      sel_r <= `DMC_SEL_RESET;
    end else if (sel_wr_en) begin
      sel_r <= sel_wr_data;
    end
  end

  // -------------------------------------------------------------
  // Field decode
  // -------------------------------------------------------------
  logic mux_en;
  logic force_lvl;
  logic man_out;
  logic [2:0] lbk_sel;
  dmc_cfg_t cfg;
  logic lbk_active;
  logic lbk_level;
  logic chan_level;
  logic sdo_force;

  assign mux_en = ctrl_r[`DMC_BIT_MUX_EN];
  assign force_lvl = ctrl_r[`DMC_BIT_SDO_FORCE];
  assign man_out = ctrl_r[`DMC_BIT_MAN_OUT];
  assign lbk_sel = ctrl_r[`DMC_LBK_HI:`DMC_LBK_LO];
  assign cfg = dmc_cfg_t'(ctrl_r[`DMC_CFG_HI:`DMC_CFG_LO]);
  assign chan_level = (32'(sel_r) < NUM_CH) ? digital_channels[sel_r] : 1'b0;
  assign sdo_force = mux_en && (cfg == DMC_CFG_LOOPBACK) && (lbk_sel == `DMC_LBK_SDO);

  dmc_loopback_sel u_lbk (
    .loopback_input_select(lbk_sel),
    .serial_out_force_level(force_lvl),
    .error_in(error_in),
    .chip_select_pin(chip_select_pin),
    .sdi_in(sdi_in),
    .sck_in(sck_in),
    .active(lbk_active),
    .level(lbk_level)
  );

  // -------------------------------------------------------------
  // Diagnostic pin
  // -------------------------------------------------------------
  logic diag_nxt;
  logic diag_oe_nxt;
  logic ana_en_nxt;
  always_comb begin
    diag_nxt = 1'b0;
    diag_oe_nxt = 1'b0;
    ana_en_nxt = 1'b0;
    if (mux_en) begin
      case (cfg)
        DMC_CFG_MANUAL: begin
          diag_oe_nxt = 1'b1;
          diag_nxt = man_out;
        end
        DMC_CFG_DIGITAL: begin
          diag_oe_nxt = 1'b1;
          diag_nxt = (lbk_sel == `DMC_LBK_NONE) ? chan_level : 1'b0;
        end
        DMC_CFG_ANALOG: begin
          ana_en_nxt = (lbk_sel == `DMC_LBK_NONE);
        end
        DMC_CFG_LOOPBACK: begin
          diag_oe_nxt = 1'b1;
          diag_nxt = lbk_active ? lbk_level : 1'b0;
        end
        default: begin
          diag_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      diag_output_pin <= 1'b0;
    end else begin
      diag_output_pin <= diag_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      diag_output_oe <= 1'b0;
    end else begin
      diag_output_oe <= diag_oe_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      analog_mux_en <= 1'b0;
    end else begin
      analog_mux_en <= ana_en_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      analog_mux_sel <= `DMC_SEL_RESET;
    end else begin
      analog_mux_sel <= sel_r;
    end
  end

  // -------------------------------------------------------------
  // Serial data out
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (sdo_force && chip_select_pin) begin
      sdo_out <= force_lvl;
      sdo_oe <= 1'b1;
    end else begin
      sdo_out <= sdo_func_data;
      sdo_oe <= sdo_func_oe;
    end
  end

  // -------------------------------------------------------------
  // Readback
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      diag_control_reg <= `DMC_CTRL_RESET;
    end else begin
      diag_control_reg <= ctrl_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      diag_channel_select <= `DMC_SEL_RESET;
    end else begin
      diag_channel_select <= sel_r;
    end
  end
endmodule
`default_nettype wire

// [tb/dmc_checker_assertions.sv]
// Purpose: Port assertions for the diagnostic mux control
// Assumes: Readback and pins lag the register alike
// Notes: Bound to dmc_diag_mux_ctrl by the bind below
`timescale 1ns/1ps
`default_nettype none
module dmc_checker
  import dmc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic device_reset_state,
  input wire logic ctrl_wr_en,
  input wire logic ctrl_lock,
  input wire logic [7:0] diag_control_reg,
  input wire logic [7:0] diag_channel_select,
  input wire logic error_in,
  input wire logic chip_select_pin,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic diag_output_pin,
  input wire logic diag_output_oe,
  input wire logic analog_mux_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic en, lp;
  logic [2:0] lb;
  assign en = diag_control_reg[7];
  assign lb = diag_control_reg[4:2];
  assign lp = en && diag_control_reg[1:0] == DMC_CFG_LOOPBACK;
  a_off_tristate: assert property (!en |-> !diag_output_oe)
    else $error("pin driven while off");
  a_manual_level: assert property (en && diag_control_reg[1:0] == DMC_CFG_MANUAL |->
    diag_output_oe && diag_output_pin == diag_control_reg[5]) else $error("manual level");
  a_analog_mode: assert property (en && diag_control_reg[1:0] == DMC_CFG_ANALOG |->
    !diag_output_oe && analog_mux_en == (lb == 3'h0)) else $error("analog mode");
  a_loop_error: assert property (lp && lb == 3'h1 |-> diag_output_pin == $past(error_in))
    else $error("error input loop");
  a_sdo_force: assert property (lp && lb == 3'h7 && $past(chip_select_pin) |->
    sdo_oe && sdo_out == diag_control_reg[6]) else $error("serial out force");
  a_sdo_loop: assert property (lp && lb == 3'h7 |-> diag_output_pin == diag_control_reg[6])
    else $error("forced level loop");
  a_lock_hold: assert property (ctrl_wr_en && ctrl_lock && !device_reset_state |->
    ##2 $stable(diag_control_reg)) else $error("locked write taken");
  a_dev_clear: assert property (device_reset_state |-> ##2
    (diag_control_reg == 8'h00 && diag_channel_select == 8'h00)) else $error("no clear");
  c_force: cover property (lp && lb == 3'h7 && sdo_oe);
  c_locked: cover property (ctrl_wr_en && ctrl_lock);
  c_digital: cover property (en && diag_control_reg[1:0] == DMC_CFG_DIGITAL);
endmodule
bind dmc_diag_mux_ctrl dmc_checker u_chk (.*);
`default_nettype wire

// [tb/dmc_mcu_model.sv]
// Purpose: Controller side watching a driven pin
// Assumes: No pull on the pin
// Notes: Released pin shows inverse of last level
`timescale 1ns/1ps
`default_nettype none
module dmc_mcu_model (
  input wire logic clk,
  input wire logic oe,
  input wire logic val,
  output logic seen
);
  logic last_r = 1'b0;
  always @(posedge clk) begin
    if (oe) begin
      last_r <= val;
    end
  end
  assign seen = oe ? val : ~last_r;
endmodule
`default_nettype wire

// [tb/tb_diagnostic_output_mux_control.sv]
// Purpose: Bench for the diagnostic mux control
// Assumes: Writes show two edges after the strobe
// Notes: Row table, then hand tests
`timescale 1ns/1ps
`default_nettype none
module tb_diagnostic_output_mux_control;
  logic clk = 0, arst_n = 0, drs = 0, cwe = 0, lk = 0, swe = 0;
  logic [7:0] wd = 8'h00, creg, csel;
  logic [3:0] pn = 4'h0;
  logic [255:0] ch = 256'h1;
  logic so, soe, dp, doe, ds, ss, am, sfd = 0, sfo = 0;
  logic [7:0] asl;
  int miscompares = 0, comparisons = 0;
  logic [13:0] rows [15] = '{{8'h00,4'hf,2'h0}, {8'h80,4'hf,2'h2}, {8'ha0,4'h0,2'h3},
    {8'h83,4'hf,2'h2}, {8'h9b,4'hf,2'h2},
    {8'h87,4'h8,2'h3}, {8'h87,4'h7,2'h2}, {8'h8b,4'h4,2'h3}, {8'h8f,4'h2,2'h3},
    {8'h93,4'h1,2'h3}, {8'h97,4'hf,2'h2}, {8'h9f,4'hf,2'h2}, {8'h82,4'hf,2'h0},
    {8'h81,4'h0,2'h3}, {8'h85,4'h0,2'h2}};
  always #4 clk = ~clk;
  dmc_diag_mux_ctrl dut (.clk(clk), .arst_n(arst_n), .device_reset_state(drs),
    .ctrl_wr_en(cwe), .ctrl_wr_data(wd), .ctrl_lock(lk), .sel_wr_en(swe), .sel_wr_data(wd),
    .diag_control_reg(creg), .diag_channel_select(csel), .error_in(pn[3]),
    .chip_select_pin(pn[2]), .sdi_in(pn[1]), .sck_in(pn[0]), .sdo_func_data(sfd),
    .sdo_func_oe(sfo), .sdo_out(so), .sdo_oe(soe), .digital_channels(ch),
    .diag_output_pin(dp), .diag_output_oe(doe), .analog_mux_en(am), .analog_mux_sel(asl));
  dmc_mcu_model mcu (.clk(clk), .oe(doe), .val(dp), .seen(ds));
  dmc_mcu_model mcu_sdo (.clk(clk), .oe(soe), .val(so), .seen(ss));
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic c, input logic [7:0] d);
    cwe = c;
    swe = !c;
    wd = d;
    cyc(1);
    cwe = 0;
    swe = 0;
    cyc(1);
  endtask
  task results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    cyc(10);
    arst_n = 1;
    cyc(4);
    chk(creg, 8'h00);
    chk(csel, 8'h00);
    foreach (rows[i]) begin
      pn = rows[i][5:2];
      wr(1, rows[i][13:6]);
      chk(creg, rows[i][13:6]);
      chk({6'h0, doe, doe & ds}, {6'h0, rows[i][1:0]});
    end
    pn = 4'h4;
    wr(1, 8'hdf);
    chk({6'h0, soe, ss}, 8'h03);
    chk({6'h0, doe, dp}, 8'h03);
    pn = 4'h0;
    sfo = 1;
    cyc(1);
    chk({6'h0, soe, so}, 8'h02);
    lk = 1;
    wr(1, 8'h80);
    chk(creg, 8'hdf);
    wr(0, 8'h05);
    chk(csel, 8'h05);
    lk = 0;
    wr(1, 8'h82);
    chk({6'h0, am, doe}, 8'h02);
    chk(asl, 8'h05);
    wr(1, 8'h86);
    chk({6'h0, am, doe}, 8'h00);
    wr(1, 8'h81);
    chk({7'h0, dp}, 8'h00);
    ch = 256'h20;
    cyc(1);
    chk({7'h0, dp}, 8'h01);
    drs = 1;
    wr(0, 8'h33);
    drs = 0;
    chk(csel, 8'h00);
    chk(creg, 8'h00);
    wr(0, 8'h44);
    wr(1, 8'ha0);
    arst_n = 0;
    cyc(2);
    chk({6'h0, doe, soe}, 8'h00);
    arst_n = 1;
    cyc(4);
    chk(creg, 8'h00);
    chk(csel, 8'h00);
    results();
  end
endmodule
`default_nettype wire
